// file: core/codec_pkg.sv
// constants shared by the codec serial control port and its helpers
package codec_pkg;

	// ==============================================================
	// register addresses carried in the secondary word
	localparam logic [4:0] REG_NOOP = 5'h00;
	localparam logic [4:0] REG_CTRL1 = 5'h01;
	localparam logic [4:0] REG_CTRL2 = 5'h02;
	localparam logic [4:0] REG_CTRL3 = 5'h03;
	localparam logic [4:0] REG_CTRL4 = 5'h04;
	localparam logic [4:0] REG_TEST_A = 5'h05;
	localparam logic [4:0] REG_TEST_B = 5'h06;

	// ==============================================================
	// reset value of every control register
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ==============================================================
	// control register 1 fields
	localparam int CTRL1_SOFT_RESET = 7;
	localparam int CTRL1_POWER_DOWN = 6;
	localparam int CTRL1_DIG_LOOP = 1;
	localparam int CTRL1_DAC_16BIT = 0;

	// control register 2 fields
	localparam int CTRL2_FIR_OVF = 5;
	localparam int CTRL2_ANA_LOOP = 3;
	localparam int CTRL2_ADC_16BIT = 0;

	// control register 3 fields
	localparam int CTRL3_SLAVES_HI = 7;
	localparam int CTRL3_SLAVES_LO = 6;
	localparam int CTRL3_DELAY_HI = 5;
	localparam int CTRL3_DELAY_LO = 0;

	// control register 4 fields
	localparam int CTRL4_PLL_BYPASS = 7;
	localparam int CTRL4_IN_GAIN_HI = 6;
	localparam int CTRL4_IN_GAIN_LO = 5;
	localparam int CTRL4_OUT_GAIN_HI = 4;
	localparam int CTRL4_OUT_GAIN_LO = 3;
	localparam int CTRL4_RATE_N_HI = 2;
	localparam int CTRL4_RATE_N_LO = 0;

	// ==============================================================
	// secondary word layout
	localparam int SEC_READ_BIT = 13;
	localparam int SEC_ADDR_HI = 12;
	localparam int SEC_ADDR_LO = 8;

	// ==============================================================
	// frame timing, in shift clocks
	localparam int WORD_BITS = 16;
	localparam logic [4:0] WORD_BITS_CNT = 5'h10;
	localparam logic [4:0] READBACK_CNT = 5'h07;
	localparam logic [7:0] PRIMARY_POS = 8'h00;
	localparam logic [7:0] SECONDARY_POS = 8'h80;
	localparam logic [6:0] FS_HIGH_POS = 7'h10;

endpackage

// file: core/codec_serial_control_port.sv
// serial data and control port of the voice codec, device side
// Function
// R01 - address 0 completes frame, changes nothing
// R02 - host never writes test registers 5, 6
// R03 - sample rate from master clock over 128N/512N
// R04 - host bypasses PLL below 7 kHz
// R05 - shift clock is 256 times sample rate
// R06 - ADC word out MSB first, rising edges
// R07 - ADC format 16 or 15+1, default 15+1
// R08 - 15+1 ADC LSB carries master/slave role
// R09 - read bit plus address returns register same frame
// R10 - write frames return zero low data byte
// R11 - secondary output MSB carries role flag
// R12 - echo read bit, address; data last byte
// R13 - DAC word sampled on falling edges
// R14 - 15+1 DAC LSB is secondary request flag
// R15 - host requests secondary via LSB or pin
// R16 - read bit set blocks any register write
// R17 - zero upper byte is no-op to register 0
// R18 - programming bits sampled on falling edges
// R19 - unaddressed registers keep reset defaults
// R20 - register 3 holds delay and slave count
// R21 - register 4 holds gains, N, PLL choice
// R22 - host drives top two command bits zero
// R23 - 16-clock transfer, frames every 256 clocks
// R24 - master select high drives clock and sync
// R25 - slave output silent until slave count set
// R26 - hardware request sampled on sync rising edge
`timescale 1ns/1ps
`default_nettype none

module codec_serial_control_port (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic master_select,
	input wire logic mclk_tick,
	input wire logic pll_tick,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic frame_sync_n_in,
	output logic frame_sync_n_out,
	output logic frame_sync_n_oe,
	input wire logic din,
	output logic dout,
	output logic dout_oe,
	input wire logic hw_secondary_request,
	input wire logic [codec_pkg::WORD_BITS-1:0] adc_sample,
	input wire logic fir_overflow,
	output logic [codec_pkg::WORD_BITS-1:0] dac_word,
	output logic dac_strobe,
	output logic soft_power_down,
	output logic analog_loopback,
	output logic pll_bypass,
	output logic [1:0] input_gain,
	output logic [1:0] output_gain,
	output logic [5:0] fsd_delay,
	output logic [1:0] slave_count
);
	import codec_pkg::*;

	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] ctrl3;
		logic [7:0] ctrl4;
		logic sclk_q;
		logic fs_q;
		logic active;
		logic secondary;
		logic [4:0] fall_cnt;
		logic [15:0] out_sh;
		logic [15:0] in_sh;
		logic drive;
		logic pending;
		logic [15:0] dac_word;
		logic dac_strobe;
	} port_state_t;

	localparam port_state_t STATE_RESET = '{fs_q: 1'b1, default: '0};

	port_state_t s, next_s;

	logic half_tick, base_tick, gen_sclk, gen_fs_n;
	logic sclk_lvl, fs_lvl, rise, fall, fs_fall, fs_rise;
	logic prim_done, sec_done, dout_allowed, echo;
	logic [15:0] done_word, adc_src, adc_word;
	logic [7:0] wr_data;
	logic [4:0] wr_addr;

	// ==============================================================
	// clock generation (master role)
	// PLL mode runs on the 4x tick, so both modes divide by N per half shift clock
	assign base_tick = s.ctrl4[CTRL4_PLL_BYPASS] ? mclk_tick : pll_tick; // R03

	rate_divider u_rate_divider (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.base_tick(base_tick),
		.rate_n(s.ctrl4[CTRL4_RATE_N_HI:CTRL4_RATE_N_LO]),
		.half_tick(half_tick)
	);

	frame_generator u_frame_generator (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.enable(master_select),
		.half_tick(half_tick),
		.secondary_pending(s.pending),
		.sclk(gen_sclk),
		.frame_sync_n(gen_fs_n)
	);

	// ==============================================================
	// serial timing events, from own clocks or the master's
	assign sclk_lvl = master_select ? gen_sclk : sclk_in; // R24
	assign fs_lvl = master_select ? gen_fs_n : frame_sync_n_in; // R24
	assign rise = sclk_lvl && !s.sclk_q;
	assign fall = !sclk_lvl && s.sclk_q;
	assign fs_fall = !fs_lvl && s.fs_q;
	assign fs_rise = fs_lvl && !s.fs_q;

	assign dout_allowed = master_select ||
		(s.ctrl3[CTRL3_SLAVES_HI:CTRL3_SLAVES_LO] != 2'h0); // R25

	assign adc_src = s.ctrl1[CTRL1_DIG_LOOP] ? s.dac_word : adc_sample;
	assign adc_word = s.ctrl2[CTRL2_ADC_16BIT] ? adc_src :
		{adc_src[15:1], master_select}; // R07 R08

	assign done_word = {s.in_sh[14:0], din};
	assign wr_addr = done_word[SEC_ADDR_HI:SEC_ADDR_LO];
	assign wr_data = done_word[7:0];

	function automatic logic [7:0] reg_read(input port_state_t st, input logic [4:0] addr);
		logic [7:0] val;
		val = 8'h00;
		unique case (addr)
			REG_CTRL1: val = st.ctrl1;
			REG_CTRL2: val = st.ctrl2;
			REG_CTRL3: val = st.ctrl3;
			REG_CTRL4: val = st.ctrl4;
			default: val = 8'h00;
		endcase
		return val;
	endfunction

	// ==============================================================
	// frame engine and register file
	always_comb begin
		next_s = s;
		next_s.dac_strobe = 1'b0;
		next_s.sclk_q = sclk_lvl;
		next_s.fs_q = fs_lvl;
		prim_done = 1'b0;
		sec_done = 1'b0;
		if (fs_fall) begin
			next_s.active = 1'b1;
			next_s.fall_cnt = 5'h00;
			next_s.secondary = s.pending;
			next_s.pending = 1'b0;
			// software power down keeps only the secondary traffic alive
			next_s.drive = dout_allowed && (s.pending || !s.ctrl1[CTRL1_POWER_DOWN]);
			if (s.pending) begin
				next_s.out_sh = {master_select, 15'h0000}; // R11
			end else begin
				next_s.out_sh = adc_word; // R06
			end
		end else if (s.active) begin
			if (fall && s.fall_cnt < WORD_BITS_CNT) begin
				next_s.in_sh = done_word; // R13 R18
				next_s.fall_cnt = 5'(s.fall_cnt + 5'h01);
				if (s.secondary && s.fall_cnt == READBACK_CNT) begin
					// address is complete here, data byte shifts out next
					next_s.out_sh[14:7] = done_word[5] ?
						reg_read(s, done_word[4:0]) : 8'h00; // R09 R10 R12
				end
				if (s.fall_cnt == 5'(WORD_BITS_CNT - 5'h01)) begin
					sec_done = s.secondary;
					prim_done = !s.secondary;
				end
			end
			if (rise && s.fall_cnt != 5'h00 && s.fall_cnt < WORD_BITS_CNT) begin
				next_s.out_sh = {s.out_sh[14:0], 1'b0}; // R06
			end
		end
		if (fs_rise) begin
			next_s.active = 1'b0;
			next_s.drive = 1'b0;
			if (s.active && !s.secondary && hw_secondary_request) begin
				next_s.pending = 1'b1; // R26
			end
		end
		if (prim_done) begin
			if (!s.ctrl1[CTRL1_DAC_16BIT]) begin
				next_s.dac_word = {done_word[15:1], 1'b0}; // R14
				if (done_word[0]) begin
					next_s.pending = 1'b1; // R14
				end
			end else begin
				next_s.dac_word = done_word; // R13
			end
			next_s.dac_strobe = !s.ctrl1[CTRL1_POWER_DOWN];
		end
		if (sec_done) begin
			// zero upper byte, read requests and the no-op address never write
			if (done_word[15:8] != 8'h00 && !done_word[SEC_READ_BIT]) begin // R16 R17
				unique case (wr_addr)
					REG_CTRL1: begin
						if (wr_data[CTRL1_SOFT_RESET]) begin
							next_s.ctrl1 = CTRL_RESET;
							next_s.ctrl2 = CTRL_RESET;
							next_s.ctrl3 = CTRL_RESET;
							next_s.ctrl4 = CTRL_RESET;
						end else begin
							next_s.ctrl1 = wr_data;
						end
					end
					REG_CTRL2: begin
						next_s.ctrl2 = wr_data;
						next_s.ctrl2[CTRL2_FIR_OVF] = s.ctrl2[CTRL2_FIR_OVF];
					end
					REG_CTRL3: next_s.ctrl3 = wr_data; // R20
					REG_CTRL4: next_s.ctrl4 = wr_data; // R21
					default: begin
						// no-op address and test registers are left alone
						next_s.ctrl1 = s.ctrl1; // R01
					end
				endcase
			end
			if (done_word[SEC_READ_BIT] && wr_addr == REG_CTRL2) begin
				next_s.ctrl2[CTRL2_FIR_OVF] = 1'b0;
			end
		end
		// a new overflow beats the clear-on-read in the same cycle
		if (fir_overflow) begin
			next_s.ctrl2[CTRL2_FIR_OVF] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ==============================================================
	// pins and configuration outputs
	// echo bits follow din directly: they are due before they are sampled
	assign echo = s.active && s.secondary && s.fall_cnt != 5'h00 && s.fall_cnt <= READBACK_CNT;
	assign dout = echo ? din : s.out_sh[15]; // R12
	// in slave role, clearing the slave count in mid-frame releases the line at once
	assign dout_oe = s.drive && dout_allowed; // R25
	assign sclk_out = gen_sclk; // R05
	assign sclk_oe = master_select; // R24
	assign frame_sync_n_out = gen_fs_n;
	assign frame_sync_n_oe = master_select; // R24
	assign dac_word = s.dac_word;
	assign dac_strobe = s.dac_strobe;
	assign soft_power_down = s.ctrl1[CTRL1_POWER_DOWN];
	assign analog_loopback = s.ctrl2[CTRL2_ANA_LOOP];
	assign pll_bypass = s.ctrl4[CTRL4_PLL_BYPASS];
	assign input_gain = s.ctrl4[CTRL4_IN_GAIN_HI:CTRL4_IN_GAIN_LO];
	assign output_gain = s.ctrl4[CTRL4_OUT_GAIN_HI:CTRL4_OUT_GAIN_LO];
	assign fsd_delay = s.ctrl3[CTRL3_DELAY_HI:CTRL3_DELAY_LO];
	assign slave_count = s.ctrl3[CTRL3_SLAVES_HI:CTRL3_SLAVES_LO];

	// ==============================================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	a_slave_silent: assert property (
		!master_select && s.ctrl3[7:6] == 2'h0 |-> !dout_oe) // R25
		else $error("slave drove data before slave count was set");

	a_read_no_write: assert property (
		sec_done && done_word[13] |=> $stable(s.ctrl1) && $stable(s.ctrl3) && $stable(s.ctrl4)) // R16
		else $error("register changed during a readback frame");

	a_noop_stable: assert property (
		sec_done && done_word[15:8] == 8'h00 |=> $stable(s.ctrl1) && $stable(s.ctrl4)) // R17
		else $error("no-op word changed a register");

	a_write_ctrl4: assert property (
		sec_done && done_word[15:8] == 8'h04 |=> s.ctrl4 == $past(done_word[7:0])) // R21
		else $error("write to register 4 did not take");

	a_adc_role_lsb: assert property (
		fs_fall && !s.pending && !s.ctrl2[0] |=> s.out_sh[0] == $past(master_select)) // R08
		else $error("15+1 sample lacks role flag in its lsb");

	a_sec_role_msb: assert property (
		fs_fall && s.pending |=> s.out_sh[15] == $past(master_select) && s.secondary) // R11
		else $error("secondary word lacks role flag on top");

	a_write_zero_data: assert property (
		s.active && s.secondary && fall && s.fall_cnt == 5'h07 && !din && s.in_sh[4] == 1'b0
		|=> s.out_sh[14:7] == 8'h00) // R10
		else $error("write frame returned nonzero data byte");

	a_dac_strobe_cause: assert property (
		dac_strobe |-> $past(s.active && !s.secondary && fall && s.fall_cnt == 5'h0f)) // R13
		else $error("dac strobe without a completed primary word");

	a_hw_request: assert property (
		fs_rise && s.active && !s.secondary && hw_secondary_request |=> s.pending) // R26
		else $error("hardware request was not latched at frame sync rise");

	a_frame_length: assert property (
		s.active && fall && s.fall_cnt == 5'h0f |=> s.fall_cnt == 5'h10 ##1 !fall || s.fall_cnt == 5'h10) // R23
		else $error("transfer interval did not stop at sixteen bits");

	a_dout_release: assert property (
		fs_rise |=> !dout_oe) // R23
		else $error("data line still driven after frame sync rose");

	a_dac_lsb_flag: assert property (
		prim_done && !s.ctrl1[CTRL1_DAC_16BIT] |=> !s.dac_word[0]) // R14
		else $error("request flag leaked into the dac word");

	c_primary_done: cover property (prim_done);
	c_secondary_read: cover property (sec_done && done_word[13]);
	c_secondary_write: cover property (sec_done && !done_word[13] && done_word[15:8] != 8'h00);
	c_dac_strobe: cover property (dac_strobe ##[1:1000] dac_strobe);
	c_master_frame: cover property (master_select && fs_fall);

endmodule

`default_nettype wire

// file: core/frame_generator.sv
// master-role shift clock and frame sync generator
`timescale 1ns/1ps
`default_nettype none

module frame_generator (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic half_tick,
	input wire logic secondary_pending,
	output logic sclk,
	output logic frame_sync_n
);
	import codec_pkg::*;

	typedef struct packed {
		logic sclk;
		logic fs_n;
		logic [7:0] pos;
	} gen_state_t;

	localparam gen_state_t GEN_RESET = '{sclk: 1'b0, fs_n: 1'b1, pos: 8'hff};

	gen_state_t s, next_s;

	always_comb begin
		next_s = s;
		if (!enable) begin
			next_s = GEN_RESET;
		end else if (half_tick) begin
			next_s.sclk = !s.sclk;
			if (!s.sclk) begin
				next_s.pos = 8'(s.pos + 8'h01);
				// primary at 0, optional secondary half a frame later
				if (next_s.pos == PRIMARY_POS ||
						(next_s.pos == SECONDARY_POS && secondary_pending)) begin
					next_s.fs_n = 1'b0; // R23
				end else if (next_s.pos[6:0] == FS_HIGH_POS) begin
					next_s.fs_n = 1'b1; // R23
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s <= GEN_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign sclk = s.sclk;
	assign frame_sync_n = s.fs_n;

	// ==============================================================
	// checks
	a_fs_position: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$fell(s.fs_n) |-> (s.pos == PRIMARY_POS || s.pos == SECONDARY_POS)) // R23
		else $error("frame sync fell away from a frame position");

endmodule

`default_nettype wire

// file: core/rate_divider.sv
// divides the sample-rate base tick by N into half shift-clock periods
`timescale 1ns/1ps
`default_nettype none

module rate_divider (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic base_tick,
	input wire logic [2:0] rate_n,
	output logic half_tick
);
	import codec_pkg::*;

	typedef struct packed {
		logic [2:0] cnt;
		logic pulse;
	} div_state_t;

	div_state_t s, next_s;

	// field value 0 stands for N = 8, so the 3-bit compare wraps on its own
	always_comb begin
		next_s = s;
		next_s.pulse = 1'b0;
		if (base_tick) begin
			if (s.cnt == 3'(rate_n - 3'h1)) begin
				next_s.cnt = 3'h0;
				next_s.pulse = 1'b1;
			end else begin
				next_s.cnt = 3'(s.cnt + 3'h1);
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign half_tick = s.pulse;

endmodule

`default_nettype wire

// file: verification/host_port.sv
// host serial port model that clocks the codec in slave role
`timescale 1ns/1ps
`default_nettype none

module host_port #(
	parameter int HALF = 3
) (
	input wire logic clk_sys,
	output logic sclk,
	output logic frame_sync_n,
	output logic din,
	output logic hw_secondary_request,
	input wire logic dout,
	input wire logic dout_oe
);
	// ==============================================================
	// line state
	logic last_bit;
	logic line;

	initial begin
		last_bit = 1'b0;
		sclk = 1'b0;
		frame_sync_n = 1'b1;
		din = 1'b0;
		hw_secondary_request = 1'b0;
	end

	// no pull on the data line: a released line shows the inverse of its last bit
	always @(posedge clk_sys) begin
		if (dout_oe) begin
			last_bit <= dout;
		end
	end
	assign line = dout_oe ? dout : ~last_bit;

	// ==============================================================
	// one 16-bit transfer; shift clock stands low between frames
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic xfer(input logic [15:0] w, input logic req, output logic [15:0] r,
			output logic oe_seen);
		oe_seen = 1'b0;
		r = '0;
		@(posedge clk_sys);
		frame_sync_n <= 1'b0;
		hw_secondary_request <= req;
		wait_clk(HALF);
		for (int i = 15; i >= 0; i--) begin
			sclk <= 1'b1;
			din <= w[i];
			wait_clk(HALF);
			r[i] = line;
			oe_seen = oe_seen | dout_oe;
			sclk <= 1'b0;
			wait_clk(HALF);
		end
		sclk <= 1'b1;
		frame_sync_n <= 1'b1;
		wait_clk(HALF);
		sclk <= 1'b0;
		din <= ~w[0];
		wait_clk(HALF);
		// request held past the sync rise so the sampling edge sees it
		hw_secondary_request <= 1'b0;
		wait_clk(4 * HALF);
	endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking testbench for the codec serial control port in slave role, then master role
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import codec_pkg::*;

	// ==============================================================
	// signals
	logic clk_sys, sys_rst, sclk_in, frame_sync_n_in, din, hw_req, dout, dout_oe;
	logic sclk_out, sclk_oe, fs_out, fs_oe, dac_strobe;
	logic soft_power_down, analog_loopback, pll_bypass;
	logic [15:0] adc_sample, dac_word;
	logic [1:0] input_gain, output_gain, slave_count;
	logic [5:0] fsd_delay;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;
	logic master_sel = 1'b0;
	logic pll_tick = 1'b0;
	logic fir_ovf = 1'b0;

	codec_serial_control_port DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.master_select(master_sel), .mclk_tick(1'b0), .pll_tick(pll_tick),
		.sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
		.frame_sync_n_in(frame_sync_n_in), .frame_sync_n_out(fs_out),
		.frame_sync_n_oe(fs_oe), .din(din), .dout(dout), .dout_oe(dout_oe),
		.hw_secondary_request(hw_req), .adc_sample(adc_sample), .fir_overflow(fir_ovf),
		.dac_word(dac_word), .dac_strobe(dac_strobe), .soft_power_down(soft_power_down),
		.analog_loopback(analog_loopback), .pll_bypass(pll_bypass),
		.input_gain(input_gain), .output_gain(output_gain), .fsd_delay(fsd_delay),
		.slave_count(slave_count));

	host_port #(.HALF(3)) host (.clk_sys(clk_sys), .sclk(sclk_in),
		.frame_sync_n(frame_sync_n_in), .din(din), .hw_secondary_request(hw_req),
		.dout(dout), .dout_oe(dout_oe));

	// ==============================================================
	// clock, reset, timeout
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			stop_test();
		end
	end

	// ==============================================================
	// comparison and verdict
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("BAD %s expected %h seen %h", what, exp, seen);
			fail_count++;
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hardware-requested secondary access; the host never writes the test registers
	task automatic reg_access(input logic [15:0] cmd, output logic [15:0] r);
		logic [15:0] pr;
		logic oe;
		host.xfer(16'h0000, 1'b1, pr, oe);
		host.xfer(cmd, 1'b0, r, oe);
	endtask

	// ==============================================================
	// scenarios
	task automatic t_reset();
		check("ctrl outputs", {1'b0, soft_power_down, analog_loopback, pll_bypass, input_gain,
			output_gain, fsd_delay, slave_count}, 16'h0000);
		check("drivers off", {13'h0000, dout_oe, sclk_oe, fs_oe}, 16'h0000);
	endtask

	task automatic t_silent_slave();
		logic [15:0] r;
		logic oe;
		@(posedge clk_sys);
		adc_sample <= 16'h1234;
		host.xfer(16'hA5A7, 1'b0, r, oe);
		check("slave oe", {15'h0000, oe}, 16'h0000);
		check("dac word 15+1", dac_word, 16'hA5A6);
		host.xfer(16'h0345, 1'b0, r, oe);
		check("slave count", {14'h0000, slave_count}, 16'h0001);
		check("fsd delay", {10'h000, fsd_delay}, 16'h0005);
	endtask

	task automatic t_adc_primary();
		logic [15:0] r;
		logic oe;
		@(posedge clk_sys);
		adc_sample <= 16'hC3A5;
		host.xfer(16'h0000, 1'b0, r, oe);
		check("slave oe on", {15'h0000, oe}, 16'h0001);
		check("adc word", r, 16'hC3A4);
	endtask

	task automatic t_read_write();
		logic [15:0] r;
		reg_access(16'h2300, r);
		check("read ctrl3", r, 16'h2345);
		reg_access(16'h049A, r);
		check("write reply", r, 16'h0400);
		check("ctrl4 outs", {11'h000, pll_bypass, input_gain, output_gain}, 16'h0003 | 16'h0010);
		reg_access(16'h2400, r);
		check("read ctrl4", r, 16'h249A);
	endtask

	task automatic t_no_write();
		logic [15:0] r;
		reg_access(16'h21FF, r);
		check("read ctrl1", r, 16'h2100);
		check("power down", {15'h0000, soft_power_down}, 16'h0000);
		reg_access(16'h2100, r);
		check("ctrl1 kept", r, 16'h2100);
		reg_access(16'h00FF, r);
		check("noop reply", r, 16'h0000);
		check("ctrl3 kept", {8'h00, slave_count, fsd_delay}, 16'h0045);
		check("bypass kept", {15'h0000, pll_bypass}, 16'h0001);
	endtask

	task automatic t_formats();
		logic [15:0] r;
		logic oe;
		reg_access(16'h0209, r);
		check("analog loop", {15'h0000, analog_loopback}, 16'h0001);
		@(posedge clk_sys);
		fir_ovf <= 1'b1;
		@(posedge clk_sys);
		fir_ovf <= 1'b0;
		reg_access(16'h2200, r);
		check("flag set", r, 16'h2229);
		reg_access(16'h2200, r);
		check("flag cleared", r, 16'h2209);
		reg_access(16'h0101, r);
		@(posedge clk_sys);
		adc_sample <= 16'h5A5B;
		host.xfer(16'h8001, 1'b0, r, oe);
		check("adc 16 bit", r, 16'h5A5B);
		check("dac 16 bit", dac_word, 16'h8001);
		// bit 0 is sample data now, so this frame must be primary
		host.xfer(16'h1234, 1'b0, r, oe);
		check("dac next", dac_word, 16'h1234);
		// leaves din low, so the master frames below carry no software request
		host.xfer(16'h0001, 1'b0, r, oe);
		check("dac lsb data", dac_word, 16'h0001);
	endtask

	// master role after a second reset: PLL path, N field 0 means 8
	task automatic t_master();
		logic [15:0] r;
		logic fs_prev, sclk_prev;
		int n, nbit, strobes;
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		master_sel <= 1'b1;
		adc_sample <= 16'h6C3A;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		pll_tick <= 1'b1;
		check("master oe", {14'h0000, sclk_oe, fs_oe}, 16'h0003);
		n = 0;
		while (fs_out && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		r = '0;
		nbit = 0;
		strobes = 0;
		n = 0;
		do begin
			fs_prev = fs_out;
			sclk_prev = sclk_out;
			@(negedge clk_sys);
			n++;
			if (sclk_prev && !sclk_out && nbit < 16) begin
				r = {r[14:0], dout};
				nbit++;
			end
			if (dac_strobe) begin
				strobes++;
			end
		end while (!(fs_prev && !fs_out) && n < 5000);
		check("frame period", n[15:0], 16'h1000);
		check("master adc", r, 16'h6C3B);
		check("master strobe", strobes[15:0], 16'h0001);
	endtask

	// ==============================================================
	// main sequence
	initial begin
		sys_rst = 1'b1;
		adc_sample = 16'h0000;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (2) @(posedge clk_sys);
		t_reset();
		t_silent_slave();
		t_adc_primary();
		t_read_write();
		t_no_write();
		t_formats();
		t_master();
		stop_test();
	end
endmodule
`default_nettype wire
